//--- rtl/pbi_bus_if.sv
// Purpose: Shared bus wires between the device end and the master end
// Assumes: Undriven lines float high through pull-ups
// Notes:   Each party drives only its own _o/_oe pairs; the host also drives bus_reset_in_n
`timescale 1ns/1ps
interface pbi_bus_if;
  logic [31:0] h_ad_o;
  logic h_ad_oe;
  logic [3:0] h_cbe_n_o;
  logic h_cbe_oe;
  logic h_par_o;
  logic h_par_oe;
  logic h_frame_n_o;
  logic h_irdy_n_o;
  logic h_hs_oe;
  logic bus_reset_in_n;
  logic [31:0] d_ad_o;
  logic d_ad_oe;
  logic d_par_o;
  logic d_par_oe;
  logic d_trdy_n_o;
  logic d_stop_n_o;
  logic d_devsel_n_o;
  logic d_hs_oe;
  logic [31:0] ad;
  logic [3:0] cbe_n;
  logic par;
  logic frame_n;
  logic irdy_n;
  logic trdy_n;
  logic stop_n;
  logic devsel_n;

  // ------------------------------------------------------------
  // Wire resolution
  // ------------------------------------------------------------
  assign ad = h_ad_oe ? h_ad_o : (d_ad_oe ? d_ad_o : 32'hffff_ffff);
  assign cbe_n = h_cbe_oe ? h_cbe_n_o : 4'hf;
  assign par = h_par_oe ? h_par_o : (d_par_oe ? d_par_o : 1'h1);
  assign frame_n = h_hs_oe ? h_frame_n_o : 1'h1;
  assign irdy_n = h_hs_oe ? h_irdy_n_o : 1'h1;
  assign trdy_n = d_hs_oe ? d_trdy_n_o : 1'h1;
  assign stop_n = d_hs_oe ? d_stop_n_o : 1'h1;
  assign devsel_n = d_hs_oe ? d_devsel_n_o : 1'h1;

  modport dev (
    input ad, cbe_n, frame_n, irdy_n, bus_reset_in_n,
    output d_ad_o, d_ad_oe, d_par_o, d_par_oe, d_trdy_n_o, d_stop_n_o,
    output d_devsel_n_o, d_hs_oe
  );
  modport host (
    input ad, cbe_n, trdy_n, stop_n, devsel_n,
    output h_ad_o, h_ad_oe, h_cbe_n_o, h_cbe_oe, h_par_o, h_par_oe,
    output h_frame_n_o, h_irdy_n_o, h_hs_oe, bus_reset_in_n
  );
endinterface

//--- rtl/pbi_device.sv
// Purpose: Memory-window target end of the parallel bus
// Assumes: Bus and sys_clk share one clock; only the reset line is asynchronous
// Notes:   Burst that runs off the window end is disconnected with stop
`timescale 1ns/1ps
module pbi_device (
  input wire logic sys_clk,
  input wire logic rst,
  pbi_bus_if.dev bus,
  output logic acc_done,
  output logic acc_write,
  output logic [pbi_pkg::IDX_W-1:0] acc_index,
  output logic [31:0] acc_data
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [2:0] rsync;
    logic rst_f;
    pbi_pkg::pbi_tgt_e st;
    logic wr;
    logic [pbi_pkg::IDX_W-1:0] idx;
    logic [31:0] ad_o;
    logic ad_oe;
    logic par_o;
    logic par_oe;
    logic trdy_n;
    logic stop_n;
    logic devsel_n;
    logic hs_oe;
    logic done;
    logic acc_wr;
    logic [pbi_pkg::IDX_W-1:0] acc_idx;
    logic [31:0] acc_data;
    logic [pbi_pkg::MEM_WORDS-1:0][31:0] mem;
  } pbi_dev_s;

  localparam pbi_dev_s DEV_RST = '{
    rsync: 3'h0,
    rst_f: 1'h1,
    st: pbi_pkg::TGT_IDLE,
    wr: 1'h0,
    idx: '0,
    ad_o: pbi_pkg::AD_RST,
    ad_oe: 1'h0,
    par_o: 1'h0,
    par_oe: 1'h0,
    trdy_n: 1'h1,
    stop_n: 1'h1,
    devsel_n: 1'h1,
    hs_oe: 1'h0,
    done: 1'h0,
    acc_wr: 1'h0,
    acc_idx: '0,
    acc_data: pbi_pkg::AD_RST,
    mem: '0
  };

  pbi_dev_s q;
  pbi_dev_s d;
  logic par_now;
  logic bus_rst;
  logic hit;
  logic xfer;
  logic [3:0] cmd;

  // Parity of what is on the lines now, registered below
  pbi_parity u_par (
    .ad(bus.ad),
    .cbe_n(bus.cbe_n),
    .par(par_now)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    d = q;
    d.done = 1'h0;
    // Reset pin is the only asynchronous input; stages two and three must agree
    d.rsync = {q.rsync[1:0], bus.bus_reset_in_n};
    // A disagreeing pair keeps the last verdict, so one odd sample changes nothing
    bus_rst = (q.rsync[1] == q.rsync[2]) ? !q.rsync[1] : q.rst_f;
    d.rst_f = bus_rst;
    cmd = bus.cbe_n;
    hit = bus.ad[31:pbi_pkg::WIN_LSB] == pbi_pkg::WIN_BASE[31:pbi_pkg::WIN_LSB] &&
      (pbi_pkg::pbi_is_rd(cmd) || pbi_pkg::pbi_is_wr(cmd));
    // Phase completes only when both sides are ready
    xfer = !bus.irdy_n && !q.trdy_n && q.hs_oe;
    d.par_o = par_now;
    d.par_oe = q.ad_oe;
    unique case (q.st)
      pbi_pkg::TGT_IDLE: begin
        if (!bus.frame_n && bus.irdy_n) begin
          d.idx = bus.ad[pbi_pkg::WIN_LSB-1:2];
          d.wr = pbi_pkg::pbi_is_wr(cmd);
          if (hit) begin
            d.st = pbi_pkg::TGT_WAIT;
            d.devsel_n = 1'h0;
            d.hs_oe = 1'h1;
          end else begin
            // Not ours: interrupt ack, special, dual address and config go by
            d.st = pbi_pkg::TGT_SKIP;
          end
        end
      end
      pbi_pkg::TGT_WAIT: begin
        // One turnaround clock on the data lines before a read drives them
        d.st = pbi_pkg::TGT_DATA;
        d.trdy_n = 1'h0;
        d.ad_o = q.mem[q.idx];
        d.ad_oe = !q.wr;
      end
      pbi_pkg::TGT_DATA: begin
        if (xfer) begin
          d.done = 1'h1;
          d.acc_wr = q.wr;
          d.acc_idx = q.idx;
          d.acc_data = q.wr ? bus.ad : q.ad_o;
          if (q.wr) begin
            for (int b = 0; b < 4; b++) begin
              if (!bus.cbe_n[b]) begin
                d.mem[q.idx][8*b +: 8] = bus.ad[8*b +: 8];
              end
            end
          end
          if (bus.frame_n) begin
            d.st = pbi_pkg::TGT_TURN;
            d.trdy_n = 1'h1;
            d.devsel_n = 1'h1;
            d.ad_oe = 1'h0;
          end else if (q.idx == pbi_pkg::IDX_W'(pbi_pkg::MEM_WORDS - 1)) begin
            d.st = pbi_pkg::TGT_STOP;
            d.trdy_n = 1'h1;
            d.stop_n = 1'h0;
            d.ad_oe = 1'h0;
          end else begin
            d.idx = q.idx + 1'h1;
            d.ad_o = q.mem[q.idx + 1'h1];
          end
        end
      end
      pbi_pkg::TGT_STOP: begin
        // Hold stop until the master signals its last phase
        if (bus.frame_n && !bus.irdy_n) begin
          d.st = pbi_pkg::TGT_TURN;
          d.stop_n = 1'h1;
          d.devsel_n = 1'h1;
        end
      end
      pbi_pkg::TGT_TURN: begin
        // Lines were driven high for one clock, now released
        d.st = pbi_pkg::TGT_IDLE;
        d.hs_oe = 1'h0;
      end
      pbi_pkg::TGT_SKIP: begin
        if (bus.frame_n && bus.irdy_n) begin
          d.st = pbi_pkg::TGT_IDLE;
        end
      end
    endcase
    if (bus_rst) begin
      d = DEV_RST;
      d.rsync = {q.rsync[1:0], bus.bus_reset_in_n};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q <= DEV_RST;
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign bus.d_ad_o = q.ad_o;
  assign bus.d_ad_oe = q.ad_oe;
  assign bus.d_par_o = q.par_o;
  assign bus.d_par_oe = q.par_oe;
  assign bus.d_trdy_n_o = q.trdy_n;
  assign bus.d_stop_n_o = q.stop_n;
  assign bus.d_devsel_n_o = q.devsel_n;
  assign bus.d_hs_oe = q.hs_oe;
  assign acc_done = q.done;
  assign acc_write = q.acc_wr;
  assign acc_index = q.acc_idx;
  assign acc_data = q.acc_data;
endmodule

//--- rtl/pbi_host.sv
// Purpose: Master end of the parallel bus, driven by a simple request port
// Assumes: Bus and sys_clk share one clock
// Notes:   Every beat of a burst write carries the same word
`timescale 1ns/1ps
module pbi_host (
  input wire logic sys_clk,
  input wire logic rst,
  pbi_bus_if.host bus,
  input wire logic req,
  input wire logic [3:0] req_cmd,
  input wire logic [31:0] req_addr,
  input wire logic [31:0] req_wdata,
  input wire logic [3:0] req_be_n,
  input wire logic [3:0] req_len,
  output logic busy,
  output logic rd_valid,
  output logic [31:0] rd_data,
  output logic done,
  output logic aborted,
  output logic stopped
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    pbi_pkg::pbi_mst_e st;
    logic rst_n;
    logic [31:0] ad_o;
    logic ad_oe;
    logic [3:0] cbe_n;
    logic cbe_oe;
    logic par_o;
    logic par_oe;
    logic frame_n;
    logic irdy_n;
    logic hs_oe;
    logic wr;
    logic [3:0] cnt;
    logic [2:0] wait_cnt;
    logic busy;
    logic rvalid;
    logic [31:0] rdata;
    logic done;
    logic abort;
    logic stopped;
  } pbi_host_s;

  localparam pbi_host_s HOST_RST = '{
    st: pbi_pkg::MST_IDLE,
    rst_n: 1'h0,
    ad_o: pbi_pkg::AD_RST,
    ad_oe: 1'h0,
    cbe_n: 4'hf,
    cbe_oe: 1'h0,
    par_o: 1'h0,
    par_oe: 1'h0,
    frame_n: 1'h1,
    irdy_n: 1'h1,
    hs_oe: 1'h0,
    wr: 1'h0,
    cnt: 4'h0,
    wait_cnt: 3'h0,
    busy: 1'h0,
    rvalid: 1'h0,
    rdata: pbi_pkg::AD_RST,
    done: 1'h0,
    abort: 1'h0,
    stopped: 1'h0
  };

  pbi_host_s q;
  pbi_host_s d;
  logic par_now;
  logic ends;

  pbi_parity u_par (
    .ad(bus.ad),
    .cbe_n(bus.cbe_n),
    .par(par_now)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    d = q;
    d.rst_n = 1'h1;
    d.rvalid = 1'h0;
    d.done = 1'h0;
    d.par_o = par_now;
    d.par_oe = q.ad_oe;
    ends = !q.irdy_n && (!bus.trdy_n || !bus.stop_n);
    unique case (q.st)
      pbi_pkg::MST_IDLE: begin
        if (req) begin
          d.st = pbi_pkg::MST_ADDR;
          d.busy = 1'h1;
          d.abort = 1'h0;
          d.stopped = 1'h0;
          d.wr = pbi_pkg::pbi_is_wr(req_cmd);
          d.cnt = (req_len == 4'h0) ? pbi_pkg::LEN_ONE : req_len;
          d.ad_o = req_addr;
          d.ad_oe = 1'h1;
          d.cbe_n = req_cmd;
          d.cbe_oe = 1'h1;
          d.frame_n = 1'h0;
          d.hs_oe = 1'h1;
        end
      end
      pbi_pkg::MST_ADDR: begin
        d.st = pbi_pkg::MST_DATA;
        d.wait_cnt = 3'h0;
        d.irdy_n = 1'h0;
        d.frame_n = q.cnt == pbi_pkg::LEN_ONE;
        d.cbe_n = req_be_n;
        d.ad_o = req_wdata;
        d.ad_oe = q.wr;
      end
      pbi_pkg::MST_DATA: begin
        if (bus.devsel_n) begin
          d.wait_cnt = q.wait_cnt + 1'h1;
          if (q.wait_cnt == pbi_pkg::DEVSEL_WAIT - 3'h1) begin
            d.st = pbi_pkg::MST_TURN;
            d.abort = 1'h1;
            d.frame_n = 1'h1;
            d.irdy_n = 1'h1;
            d.ad_oe = 1'h0;
            d.cbe_oe = 1'h0;
          end
        end else if (ends) begin
          if (!bus.trdy_n && !q.wr) begin
            d.rvalid = 1'h1;
            d.rdata = bus.ad;
          end
          if (q.frame_n) begin
            d.st = pbi_pkg::MST_TURN;
            d.irdy_n = 1'h1;
            d.ad_oe = 1'h0;
            d.cbe_oe = 1'h0;
          end else if (!bus.stop_n) begin
            d.frame_n = 1'h1;
            d.stopped = 1'h1;
          end else begin
            d.cnt = q.cnt - 1'h1;
            d.frame_n = q.cnt == 4'h2;
          end
        end else if (!bus.stop_n && !q.frame_n) begin
          d.frame_n = 1'h1;
          d.stopped = 1'h1;
        end
      end
      pbi_pkg::MST_TURN: begin
        // Frame and ready were driven high for a clock; release them now
        d.st = pbi_pkg::MST_IDLE;
        d.hs_oe = 1'h0;
        d.busy = 1'h0;
        d.done = 1'h1;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q <= HOST_RST;
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign bus.h_ad_o = q.ad_o;
  assign bus.h_ad_oe = q.ad_oe;
  assign bus.h_cbe_n_o = q.cbe_n;
  assign bus.h_cbe_oe = q.cbe_oe;
  assign bus.h_par_o = q.par_o;
  assign bus.h_par_oe = q.par_oe;
  assign bus.h_frame_n_o = q.frame_n;
  assign bus.h_irdy_n_o = q.irdy_n;
  assign bus.h_hs_oe = q.hs_oe;
  assign bus.bus_reset_in_n = q.rst_n;
  assign busy = q.busy;
  assign rd_valid = q.rvalid;
  assign rd_data = q.rdata;
  assign done = q.done;
  assign aborted = q.abort;
  assign stopped = q.stopped;
endmodule

//--- rtl/pbi_parity.sv
// Purpose: Even parity over the address/data and command lines
// Assumes: Inputs are the resolved bus values of the current cycle
// Notes:   Caller registers the result so it lags the bus by one clock
`timescale 1ns/1ps
module pbi_parity (
  input wire logic [31:0] ad,
  input wire logic [3:0] cbe_n,
  output logic par
);
  assign par = ^{ad, cbe_n};
endmodule

//--- rtl/pbi_pkg.sv
// Purpose: Shared constants and types for the parallel bus ends
// Assumes: One clock shared by both ends and the bus, sys_clk at 20 MHz
// Notes:   The bus logic is rated for a clock up to 66 MHz
package pbi_pkg;
  // ------------------------------------------------------------
  // Command encodings
  // ------------------------------------------------------------
  localparam logic [3:0] CMD_INT_ACK = 4'h0;
  localparam logic [3:0] CMD_SPECIAL = 4'h1;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_CFG_RD = 4'ha;
  localparam logic [3:0] CMD_CFG_WR = 4'hb;
  localparam logic [3:0] CMD_MEM_RD_MULT = 4'hc;
  localparam logic [3:0] CMD_DUAL_ADDR = 4'hd;
  localparam logic [3:0] CMD_MEM_RD_LINE = 4'he;
  localparam logic [3:0] CMD_MEM_WR_INV = 4'hf;

  // ------------------------------------------------------------
  // Target window and timing
  // ------------------------------------------------------------
  localparam int MEM_WORDS = 8;
  localparam int IDX_W = 3;
  localparam int WIN_LSB = 5;
  localparam logic [31:0] WIN_BASE = 32'h0000_1000;
  localparam logic [2:0] DEVSEL_WAIT = 3'h5;
  localparam logic [3:0] LEN_ONE = 4'h1;
  localparam logic [31:0] AD_RST = 32'h0000_0000;

  // ------------------------------------------------------------
  // State machines
  // ------------------------------------------------------------
  typedef enum logic [5:0] {
    TGT_IDLE = 6'h01,
    TGT_WAIT = 6'h02,
    TGT_DATA = 6'h04,
    TGT_STOP = 6'h08,
    TGT_TURN = 6'h10,
    TGT_SKIP = 6'h20
  } pbi_tgt_e;

  typedef enum logic [3:0] {
    MST_IDLE = 4'h1,
    MST_ADDR = 4'h2,
    MST_DATA = 4'h4,
    MST_TURN = 4'h8
  } pbi_mst_e;

  function automatic logic pbi_is_rd(input logic [3:0] cmd);
    return cmd == CMD_MEM_RD || cmd == CMD_MEM_RD_MULT || cmd == CMD_MEM_RD_LINE;
  endfunction

  function automatic logic pbi_is_wr(input logic [3:0] cmd);
    return cmd == CMD_MEM_WR || cmd == CMD_MEM_WR_INV;
  endfunction
endpackage

//--- sim/pbi_bus_chk.sv
// Purpose: Concurrent checks on the wires between the two bus ends
// Assumes: Both ends on sys_clk; rst synchronous, active high
// Notes:   Window hit decode is written out here, not taken from the design
`timescale 1ns/1ps
module pbi_bus_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [31:0] ad,
  input wire logic [3:0] cbe_n,
  input wire logic par,
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire logic trdy_n,
  input wire logic stop_n,
  input wire logic devsel_n,
  input wire logic h_ad_oe,
  input wire logic h_par_oe,
  input wire logic h_hs_oe,
  input wire logic d_ad_oe,
  input wire logic d_par_oe,
  input wire logic d_hs_oe
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic hit;
  assign hit = ad[31:5] == 27'h80 && cbe_n inside {4'h6, 4'h7, 4'hc, 4'he, 4'hf};

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_par_even: assert property ((h_par_oe || d_par_oe) && $past(h_ad_oe || d_ad_oe)
    |-> ^{par, $past(ad), $past(cbe_n)} == 1'b0) else $error("parity not even");
  a_par_lag: assert property ($rose(h_ad_oe) |=> h_par_oe)
    else $error("address parity late");
  a_par_hold: assert property ($fell(d_ad_oe) |-> d_par_oe)
    else $error("parity dropped with data");
  a_addr_phase: assert property ($fell(frame_n) |-> irdy_n && h_ad_oe)
    else $error("bad address phase");
  a_frame_final: assert property ($rose(frame_n) && h_hs_oe |-> !irdy_n)
    else $error("frame ended without initiator ready");
  a_claim_time: assert property ($fell(frame_n) && hit |=> !devsel_n ##1 !trdy_n)
    else $error("claim timing wrong");
  a_miss_quiet: assert property ($fell(frame_n) && !hit |=> devsel_n [*5])
    else $error("device claimed a foreign cycle");
  a_trdy_sel: assert property (!trdy_n |-> !devsel_n)
    else $error("target ready without select");
  a_stop_end: assert property ($fell(stop_n) |-> ##[0:6] (frame_n && irdy_n))
    else $error("master ignored stop");
  a_reset_quiet: assert property (disable iff (1'b0) rst
    |=> !(h_ad_oe || d_ad_oe || h_par_oe || d_par_oe || h_hs_oe || d_hs_oe))
    else $error("lines driven in reset");
  a_host_release: assert property ($fell(h_hs_oe)
    |-> $past(frame_n) && $past(irdy_n)) else $error("master released low");
  a_dev_release: assert property ($fell(d_hs_oe)
    |-> $past(trdy_n && stop_n && devsel_n)) else $error("target released low");
endmodule

//--- sim/pbi_tb.sv
// Purpose: Host end and device end joined by one bus, checked end to end
// Assumes: sys_clk 50 ns; inputs change on the falling edge
// Notes:   Outputs sampled on the falling edge, so register updates have landed
`timescale 1ns/1ps
module tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic dev_rst = 1'b1;
  logic req = 1'b0;
  logic [3:0] req_cmd = 4'h0;
  logic [31:0] req_addr = 32'h0;
  logic [31:0] req_wdata = 32'h0;
  logic [3:0] req_be_n = 4'h0;
  logic [3:0] req_len = 4'h1;
  logic busy, rd_valid, done, aborted, stopped, acc_done, acc_write;
  logic [31:0] rd_data, acc_data;
  logic [pbi_pkg::IDX_W-1:0] acc_index;
  logic [31:0] rq[$];
  logic [3:0] bad_cmd[5] = '{4'h0, 4'h1, 4'ha, 4'hb, 4'hd};
  int n_errors = 0;
  int n_tests = 0;
  int n_acc = 0;

  always #25 sys_clk = ~sys_clk;

  pbi_bus_if pbi_bus_if_i ();
  pbi_host pbi_host_i (.sys_clk(sys_clk), .rst(rst), .bus(pbi_bus_if_i), .req(req),
    .req_cmd(req_cmd), .req_addr(req_addr), .req_wdata(req_wdata), .req_be_n(req_be_n),
    .req_len(req_len), .busy(busy), .rd_valid(rd_valid), .rd_data(rd_data), .done(done),
    .aborted(aborted), .stopped(stopped));
  pbi_device pbi_device_i (.sys_clk(sys_clk), .rst(dev_rst), .bus(pbi_bus_if_i),
    .acc_done(acc_done), .acc_write(acc_write), .acc_index(acc_index), .acc_data(acc_data));
  pbi_bus_chk pbi_bus_chk_i (.sys_clk(sys_clk), .rst(rst), .ad(pbi_bus_if_i.ad),
    .cbe_n(pbi_bus_if_i.cbe_n), .par(pbi_bus_if_i.par), .frame_n(pbi_bus_if_i.frame_n),
    .irdy_n(pbi_bus_if_i.irdy_n), .trdy_n(pbi_bus_if_i.trdy_n), .stop_n(pbi_bus_if_i.stop_n),
    .devsel_n(pbi_bus_if_i.devsel_n), .h_ad_oe(pbi_bus_if_i.h_ad_oe),
    .h_par_oe(pbi_bus_if_i.h_par_oe), .h_hs_oe(pbi_bus_if_i.h_hs_oe),
    .d_ad_oe(pbi_bus_if_i.d_ad_oe), .d_par_oe(pbi_bus_if_i.d_par_oe),
    .d_hs_oe(pbi_bus_if_i.d_hs_oe));

  always @(negedge sys_clk) begin
    if (rd_valid === 1'b1) rq.push_back(rd_data);
    if (acc_done === 1'b1) n_acc++;
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic xfer(input logic [3:0] c, input logic [31:0] a, input logic [31:0] w,
                      input logic [3:0] be, input logic [3:0] len);
    int k;
    rq.delete();
    n_acc = 0;
    @(negedge sys_clk);
    req = 1'b1;
    req_cmd = c;
    req_addr = a;
    req_wdata = w;
    req_be_n = be;
    req_len = len;
    @(negedge sys_clk);
    req = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 60) begin
      @(negedge sys_clk);
      k++;
    end
    chk("done", 32'h1, {31'h0, done});
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_write_read();
    xfer(4'h7, 32'h1004, 32'h1234_5678, 4'h0, 4'h1);
    chk("phases", 32'h1, n_acc);
    chk("windex", 32'h1, {29'h0, acc_index});
    chk("wflag", 32'h1, {31'h0, acc_write});
    chk("wdata", 32'h1234_5678, acc_data);
    xfer(4'h6, 32'h1004, 32'h0, 4'h0, 4'h1);
    chk("rcount", 32'h1, rq.size());
    chk("rdata", 32'h1234_5678, rq[0]);
  endtask

  task automatic t_byte_lanes();
    xfer(4'h7, 32'h1004, 32'hffff_ffff, 4'he, 4'h1);
    xfer(4'h7, 32'h1004, 32'h0000_0000, 4'h7, 4'h1);
    xfer(4'h6, 32'h1004, 32'h0, 4'h0, 4'h1);
    chk("lanes", 32'h0034_56ff, rq[0]);
  endtask

  task automatic t_burst();
    xfer(4'hf, 32'h1008, 32'hc3c3_0f0f, 4'h0, 4'h3);
    chk("bphases", 32'h3, n_acc);
    chk("bindex", 32'h4, {29'h0, acc_index});
    xfer(4'hc, 32'h1004, 32'h0, 4'h0, 4'h4);
    chk("bcount", 32'h4, rq.size());
    chk("bword0", 32'h0034_56ff, rq[0]);
    for (int i = 1; i < 4; i++) chk("bword", 32'hc3c3_0f0f, rq[i]);
    xfer(4'he, 32'h1010, 32'h0, 4'h0, 4'h1);
    chk("line", 32'hc3c3_0f0f, rq[0]);
    chk("rdacc", 32'hc3c3_0f0f, acc_data);
  endtask

  task automatic t_stop();
    xfer(4'h7, 32'h101c, 32'h7777_0007, 4'h0, 4'h1);
    xfer(4'he, 32'h1018, 32'h0, 4'h0, 4'h4);
    chk("scount", 32'h2, rq.size());
    chk("sword7", 32'h7777_0007, rq[1]);
    chk("stopped", 32'h1, {31'h0, stopped});
    xfer(4'h7, 32'h1018, 32'h5a5a_a5a5, 4'h0, 4'h3);
    chk("wstop", 32'h2, n_acc);
  endtask

  task automatic t_no_claim();
    foreach (bad_cmd[i]) begin
      xfer(bad_cmd[i], 32'h1000, 32'h0, 4'h0, 4'h1);
      chk("aborted", 32'h1, {31'h0, aborted});
      chk("noacc", 32'h0, n_acc);
    end
    xfer(4'h6, 32'h2000, 32'h0, 4'h0, 4'h1);
    chk("outside", 32'h1, {31'h0, aborted});
    xfer(4'h6, 32'h1000, 32'h0, 4'h0, 4'h1);
    chk("claimed", 32'h0, {31'h0, aborted});
  endtask

  // Only the master end is reset here, so a cleared word proves the bus reset pin works
  task automatic t_reset();
    @(negedge sys_clk);
    rst = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk("rbusy", 32'h0, {31'h0, busy});
    rst = 1'b0;
    repeat (6) @(negedge sys_clk);
    xfer(4'h6, 32'h101c, 32'h0, 4'h0, 4'h1);
    chk("cleared", 32'h0, rq[0]);
  endtask

  task automatic complete_run();
    $display("Checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (4000) @(posedge sys_clk);
    n_errors++;
    complete_run();
  end

  initial begin
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    dev_rst = 1'b0;
    repeat (6) @(negedge sys_clk);
    t_write_read();
    t_byte_lanes();
    t_burst();
    t_stop();
    t_no_claim();
    t_reset();
    complete_run();
  end
endmodule
